// ==== include/line_cond_pkg.sv ====
// Behaviour
// - The general-purpose pin is either input or output, set by one direction bit.
// - Writing the input value to the direction bit makes the pin an input.
// - Pin (input only), CC1, CC2 or CC3 selectable as either trigger source.
// - Every valid conditioned rising edge on the acquisition source gives one acquisition event.
// - Every valid conditioned rising edge on the frame source gives one frame event.
// - Each of the four lines has its own glitch filter.
// - A level passes only after staying stable for the configured filter time.
// - Valid levels reach internal logic delayed by the filter time.
// - Filter time is set in microseconds, 0 up to about 1 s.
// - Pin filter time unit conflict resolved: microseconds used for all lines.
// - Each line has its own independently written filter-time register.
// - Each line has its own polarity setting, invert or pass.
// - Polarity bit 1 inverts, 0 passes unchanged.
// - The spare Camera Link bit is usable as an extra output line.
package line_cond_pkg;
    localparam int NUM_LINES = 4;
    localparam int TIME_W = 20;
    localparam int CLK_MHZ = 50;
    localparam int PRESCALE_W = 6;
    localparam logic [PRESCALE_W-1:0] US_CYCLES = 6'(CLK_MHZ - 1);
    localparam logic [TIME_W-1:0] FILTER_MAX_US = 20'hf4240;
    localparam logic [TIME_W-1:0] FILTER_RST = 20'h00000;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_TIME0 = 12'h010;
    localparam logic [11:0] OFS_TIME1 = 12'h014;
    localparam logic [11:0] OFS_TIME2 = 12'h018;
    localparam logic [11:0] OFS_TIME3 = 12'h01c;
    localparam int CTRL_INV_LSB = 0;
    localparam int CTRL_DIR_BIT = 4;
    localparam int CTRL_ACQ_LSB = 8;
    localparam int CTRL_FRM_LSB = 12;
    localparam int CTRL_SPARE_BIT = 16;
    localparam int CTRL_PINOUT_BIT = 17;
    localparam logic DIR_INPUT = 1'b0;
    localparam logic DIR_OUTPUT = 1'b1;

    // Trigger source codes: bit 2 enables, bits 1:0 pick the line
    typedef enum logic [2:0]
    {
        SRC_OFF = 3'h0,
        SRC_PIN = 3'h4,
        SRC_CC1 = 3'h5,
        SRC_CC2 = 3'h6,
        SRC_CC3 = 3'h7
    } src_sel_t;

    typedef struct packed
    {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed
    {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;
endpackage : line_cond_pkg

// ==== src/glitch_filter.sv ====
`timescale 1ns/100ps
module glitch_filter
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic line_in,
    input wire logic us_tick_in,
    input wire logic [line_cond_pkg::TIME_W-1:0] time_us_in,
    output logic level_out
);
    import line_cond_pkg::*;

    typedef struct packed
    {
        logic [1:0] sync;
        logic cand;
        logic [TIME_W-1:0] count;
        logic level;
    } filt_state_t;

    filt_state_t st;
    filt_state_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.sync = {st.sync[0], line_in};
        if (st.sync[1] != st.cand)
        begin
            // Restart on change
            next_st.cand = st.sync[1];
            next_st.count = '0;
            if (time_us_in == '0)
            begin
                next_st.level = st.sync[1];
            end
        end
        else if (st.count > time_us_in)
        begin
            // The first tick after a restart can come at once, so wait one tick more
            next_st.level = st.cand;
        end
        else if (us_tick_in)
        begin
            next_st.count = st.count + 1'b1;
        end
        if (!rst_b_in)
        begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        st <= next_st;
    end

    assign level_out = st.level;

    a_short_pulse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (st.cand != st.level && st.count <= time_us_in && time_us_in != '0)
        |=> $stable(st.level))
        else $error("Filter output moved before stable time");
    a_restart_count: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (st.sync[1] != st.cand) |=> (st.count == '0))
        else $error("Filter count did not restart on change");
endmodule : glitch_filter

// ==== src/line_conditioning.sv ====
`timescale 1ns/100ps
module line_conditioning
(
    input wire logic MCLK_IN,
    input wire logic RST_B_IN,
    input wire line_cond_pkg::apb_req_t APB_REQ_IN,
    output line_cond_pkg::apb_rsp_t APB_RSP_OUT,
    input wire logic GENERAL_PURPOSE_PIN_IN,
    output logic GENERAL_PURPOSE_PIN_OUT,
    output logic GENERAL_PURPOSE_PIN_OE_OUT,
    input wire logic [2:0] CC_IN,
    input wire logic PIN_SOURCE_IN,
    output logic CL_SPARE_OUT,
    output logic ACQ_START_TRIG_OUT,
    output logic FRAME_START_TRIG_OUT,
    output logic [3:0] LINE_LEVEL_OUT
);
    import line_cond_pkg::*;

    typedef struct packed
    {
        logic [NUM_LINES-1:0] invert;
        logic dir;
        logic [2:0] acq_src;
        logic [2:0] frm_src;
        logic spare;
        logic pin_user;
        logic [NUM_LINES-1:0][TIME_W-1:0] time_us;
        logic [PRESCALE_W-1:0] prescale;
        logic us_tick;
        logic [NUM_LINES-1:0] cond_prev;
        logic acq_trig;
        logic frm_trig;
        logic pin_out;
        logic pin_oe;
        logic spare_out;
        logic [NUM_LINES-1:0] level;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;
    logic [NUM_LINES-1:0] raw;
    logic [NUM_LINES-1:0] filt;
    logic [NUM_LINES-1:0] cond;
    logic [NUM_LINES-1:0] valid;
    logic [NUM_LINES-1:0] rise;
    logic setup_ph;
    logic access_ph;

    // Line 0 is the general-purpose pin, lines 1..3 are CC1..CC3
    assign raw = {CC_IN, GENERAL_PURPOSE_PIN_IN};
    assign setup_ph = APB_REQ_IN.psel && !APB_REQ_IN.penable;
    assign access_ph = APB_REQ_IN.psel && APB_REQ_IN.penable && st.pready;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++)
        begin : g_line
            glitch_filter u_filter
            (
                .clk_in(MCLK_IN),
                .rst_b_in(RST_B_IN),
                .line_in(raw[gi]),
                .us_tick_in(st.us_tick),
                .time_us_in(st.time_us[gi]),
                .level_out(filt[gi])
            );
            assign cond[gi] = filt[gi] ^ st.invert[gi];
        end
    endgenerate

    // Pin counts only while it is an input
    assign valid = {3'b111, st.dir == DIR_INPUT};
    assign rise = cond & ~st.cond_prev & valid;

    function automatic logic pick(input logic [2:0] src, input logic [NUM_LINES-1:0] ev);
        pick = src[2] ? ev[src[1:0]] : 1'b0;
    endfunction : pick

    function automatic logic [TIME_W-1:0] clamp(input logic [31:0] v);
        clamp = (v[31:TIME_W] != '0 || v[TIME_W-1:0] > FILTER_MAX_US) ?
            FILTER_MAX_US : v[TIME_W-1:0];
    endfunction : clamp

    always_comb
    begin
        next_st = st;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        // Microsecond tick for the filter counters
        if (st.prescale == US_CYCLES)
        begin
            next_st.prescale = '0;
            next_st.us_tick = 1'b1;
        end
        else
        begin
            next_st.prescale = st.prescale + 1'b1;
            next_st.us_tick = 1'b0;
        end
        next_st.cond_prev = cond;
        next_st.acq_trig = pick(st.acq_src, rise);
        next_st.frm_trig = pick(st.frm_src, rise);
        next_st.level = cond & valid;
        next_st.pin_oe = (st.dir == DIR_OUTPUT);
        next_st.pin_out = (st.dir == DIR_OUTPUT) ? (PIN_SOURCE_IN | st.pin_user) : 1'b0;
        next_st.spare_out = st.spare;
        if (setup_ph)
        begin
            next_st.pready = 1'b1;
            next_st.prdata = '0;
            if (APB_REQ_IN.pwrite)
            begin
                unique case (APB_REQ_IN.paddr)
                    OFS_CTRL, OFS_STATUS, OFS_TIME0, OFS_TIME1, OFS_TIME2, OFS_TIME3:
                    begin
                    end
                    default:
                    begin
                        next_st.pslverr = 1'b1;
                    end
                endcase
            end
            else
            begin
                case (APB_REQ_IN.paddr)
                    OFS_CTRL:
                    begin
                        next_st.prdata[CTRL_INV_LSB +: NUM_LINES] = st.invert;
                        next_st.prdata[CTRL_DIR_BIT] = st.dir;
                        next_st.prdata[CTRL_ACQ_LSB +: 3] = st.acq_src;
                        next_st.prdata[CTRL_FRM_LSB +: 3] = st.frm_src;
                        next_st.prdata[CTRL_SPARE_BIT] = st.spare;
                        next_st.prdata[CTRL_PINOUT_BIT] = st.pin_user;
                    end
                    OFS_STATUS:
                    begin
                        next_st.prdata[NUM_LINES-1:0] = st.level;
                    end
                    OFS_TIME0:
                    begin
                        next_st.prdata[TIME_W-1:0] = st.time_us[0];
                    end
                    OFS_TIME1:
                    begin
                        next_st.prdata[TIME_W-1:0] = st.time_us[1];
                    end
                    OFS_TIME2:
                    begin
                        next_st.prdata[TIME_W-1:0] = st.time_us[2];
                    end
                    OFS_TIME3:
                    begin
                        next_st.prdata[TIME_W-1:0] = st.time_us[3];
                    end
                    default:
                    begin
                        next_st.pslverr = 1'b1;
                    end
                endcase
            end
        end
        if (access_ph && APB_REQ_IN.pwrite)
        begin
            case (APB_REQ_IN.paddr)
                OFS_CTRL:
                begin
                    next_st.invert = APB_REQ_IN.pwdata[CTRL_INV_LSB +: NUM_LINES];
                    next_st.dir = APB_REQ_IN.pwdata[CTRL_DIR_BIT];
                    next_st.acq_src = APB_REQ_IN.pwdata[CTRL_ACQ_LSB +: 3];
                    next_st.frm_src = APB_REQ_IN.pwdata[CTRL_FRM_LSB +: 3];
                    next_st.spare = APB_REQ_IN.pwdata[CTRL_SPARE_BIT];
                    next_st.pin_user = APB_REQ_IN.pwdata[CTRL_PINOUT_BIT];
                end
                OFS_TIME0:
                begin
                    next_st.time_us[0] = clamp(APB_REQ_IN.pwdata);
                end
                OFS_TIME1:
                begin
                    next_st.time_us[1] = clamp(APB_REQ_IN.pwdata);
                end
                OFS_TIME2:
                begin
                    next_st.time_us[2] = clamp(APB_REQ_IN.pwdata);
                end
                OFS_TIME3:
                begin
                    next_st.time_us[3] = clamp(APB_REQ_IN.pwdata);
                end
                default:
                begin
                end
            endcase
        end
        if (!RST_B_IN)
        begin
            next_st = '0;
            next_st.dir = DIR_INPUT;
            next_st.time_us = {NUM_LINES{FILTER_RST}};
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        st <= next_st;
    end

    always_comb
    begin
        APB_RSP_OUT.pready = st.pready;
        APB_RSP_OUT.pslverr = st.pslverr;
        APB_RSP_OUT.prdata = st.prdata;
    end
    assign GENERAL_PURPOSE_PIN_OUT = st.pin_out;
    assign GENERAL_PURPOSE_PIN_OE_OUT = st.pin_oe;
    assign CL_SPARE_OUT = st.spare_out;
    assign ACQ_START_TRIG_OUT = st.acq_trig;
    assign FRAME_START_TRIG_OUT = st.frm_trig;
    assign LINE_LEVEL_OUT = st.level;

    a_dir_exclusive: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
        (st.dir == DIR_INPUT) |=> !GENERAL_PURPOSE_PIN_OE_OUT)
        else $error("Pin driven while set as input");
    a_dir_write: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
        (access_ph && APB_REQ_IN.pwrite && APB_REQ_IN.paddr == OFS_CTRL
        && APB_REQ_IN.pwdata[CTRL_DIR_BIT] == DIR_INPUT) |=> ##1 !st.pin_oe)
        else $error("Input direction write not honoured");
    a_pin_output_blocked: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
        (st.dir == DIR_OUTPUT && st.acq_src == SRC_PIN) |=> !ACQ_START_TRIG_OUT)
        else $error("Output pin used as trigger source");
    a_acq_event: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
        (st.acq_src[2] && rise[st.acq_src[1:0]]) |=> ACQ_START_TRIG_OUT)
        else $error("Acquisition event lost");
    a_frm_event: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
        (st.frm_src[2] && rise[st.frm_src[1:0]]) |=> FRAME_START_TRIG_OUT)
        else $error("Frame event lost");
    a_trig_pulse: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
        ACQ_START_TRIG_OUT |=> !ACQ_START_TRIG_OUT)
        else $error("Trigger longer than one cycle");
    a_time_range: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
        st.time_us[0] <= FILTER_MAX_US && st.time_us[3] <= FILTER_MAX_US)
        else $error("Filter time out of range");
    a_invert_level: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
        valid[1] |=> (LINE_LEVEL_OUT[1] == ($past(filt[1]) ^ $past(st.invert[1]))))
        else $error("Polarity not applied");
    a_tick_period: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
        st.us_tick |=> !st.us_tick [*2])
        else $error("Microsecond tick too frequent");
    a_apb_one_cycle: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
        setup_ph |=> APB_RSP_OUT.pready)
        else $error("APB answer late");

    c_acq: cover property (@(posedge MCLK_IN) disable iff (!RST_B_IN) ACQ_START_TRIG_OUT);
    c_frm: cover property (@(posedge MCLK_IN) disable iff (!RST_B_IN) FRAME_START_TRIG_OUT);
    c_pin_out: cover property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
        GENERAL_PURPOSE_PIN_OE_OUT);
    c_inverted: cover property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
        st.invert[0] && LINE_LEVEL_OUT[0]);
endmodule : line_conditioning

// ==== test/line_source_model.sv ====
`timescale 1ns/100ps
module line_source_model
(
    input wire logic clk_in,
    input wire logic pin_oe_in,
    output logic [3:0] line_out,
    output logic pin_drive_out
);
    // Control lines always driven by the grabber
    initial line_out = 4'h0;
    initial pin_drive_out = 1'b1;

    // Pin released one clock after the block starts driving it
    always @(posedge clk_in)
    begin
        pin_drive_out <= ~pin_oe_in;
    end

    task automatic set_line(input int idx, input logic lvl);
        @(posedge clk_in);
        line_out[idx] <= lvl;
    endtask : set_line

    task automatic pulse(input int idx, input logic lvl, input int len);
        set_line(idx, lvl);
        repeat (len) @(posedge clk_in);
        line_out[idx] <= ~lvl;
    endtask : pulse
endmodule : line_source_model

// ==== test/tb_camera_input_line_conditioning.sv ====
`timescale 1ns/100ps
module tb_camera_input_line_conditioning;
    import line_cond_pkg::*;
    localparam logic [11:0] TOFS [4] = '{OFS_TIME0, OFS_TIME1, OFS_TIME2, OFS_TIME3};
    logic MCLK_IN = 1'b0;
    logic RST_B_IN = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    logic pin_src = 1'b0;
    logic float_pat = 1'b0;
    logic pin_o, pin_oe, spare, acq, frm, pin_drive, err, pin_wire;
    logic [3:0] lvl, line_v;
    logic [19:0] tv [4];
    logic [31:0] rng = 32'h5;
    logic [31:0] q;
    int failures = 0;
    int checks = 0;
    int acq_cnt = 0;
    int frm_cnt = 0;
    int a0, f0, da, df, j, n, bad;

    always #10 MCLK_IN = ~MCLK_IN;

    always @(posedge MCLK_IN)
    begin
        float_pat <= ~float_pat;
        acq_cnt <= acq_cnt + 32'(acq === 1'b1);
        frm_cnt <= frm_cnt + 32'(frm === 1'b1);
    end

    assign pin_wire = pin_oe ? pin_o : (pin_drive ? line_v[0] : float_pat);

    line_conditioning line_conditioning_inst
    (
        .MCLK_IN(MCLK_IN),
        .RST_B_IN(RST_B_IN),
        .APB_REQ_IN(req),
        .APB_RSP_OUT(rsp),
        .GENERAL_PURPOSE_PIN_IN(pin_wire),
        .GENERAL_PURPOSE_PIN_OUT(pin_o),
        .GENERAL_PURPOSE_PIN_OE_OUT(pin_oe),
        .CC_IN(line_v[3:1]),
        .PIN_SOURCE_IN(pin_src),
        .CL_SPARE_OUT(spare),
        .ACQ_START_TRIG_OUT(acq),
        .FRAME_START_TRIG_OUT(frm),
        .LINE_LEVEL_OUT(lvl)
    );

    line_source_model line_source_model_inst
    (
        .clk_in(MCLK_IN),
        .pin_oe_in(pin_oe),
        .line_out(line_v),
        .pin_drive_out(pin_drive)
    );

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    function automatic logic [31:0] clamp_us(input logic [19:0] v);
        return (v > FILTER_MAX_US) ? 32'(FILTER_MAX_US) : 32'(v);
    endfunction : clamp_us

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge MCLK_IN);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge MCLK_IN);
        req.penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge MCLK_IN);
            k++;
        end
        while (rsp.pready !== 1'b1 && k < 16);
        if (k >= 16)
            chk(32'h0, 32'h1);
        q = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
        chk({31'h0, err}, {31'h0, eerr});
    endtask : rd

    task automatic pulse_line(input int idx, input int len);
        a0 = acq_cnt;
        f0 = frm_cnt;
        line_source_model_inst.pulse(idx, 1'b1, len);
        repeat (60) @(posedge MCLK_IN);
        da = acq_cnt - a0;
        df = frm_cnt - f0;
    endtask : pulse_line

    task automatic end_sim();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (20000) @(posedge MCLK_IN);
        failures++;
        end_sim();
    end

    initial
    begin
        repeat (3) @(posedge MCLK_IN);
        RST_B_IN <= 1'b1;
        @(posedge MCLK_IN);
        chk({28'h0, pin_oe, acq, frm, spare}, 32'h0);
        rd(OFS_CTRL, 32'h0, 1'b0);
        rd(OFS_STATUS, 32'h0, 1'b0);
        wr(OFS_STATUS, 32'hf);
        rd(OFS_STATUS, 32'h0, 1'b0);
        rd(12'h020, 32'h0, 1'b1);
        wr(12'h024, 32'h1);
        chk({31'h0, err}, 32'h1);
        $display("test reset_map done");
        for (int i = 0; i < 4; i++)
        begin
            rng = xorshift(rng);
            tv[i] = (i == 3) ? 20'hfffff : ((i == 2) ? FILTER_MAX_US : rng[19:0]);
            wr(TOFS[i], 32'(tv[i]));
        end
        for (int i = 0; i < 4; i++)
            rd(TOFS[i], clamp_us(tv[i]), 1'b0);
        for (int i = 0; i < 4; i++)
            wr(TOFS[i], 32'h0);
        $display("test filter_time done");
        for (int i = 0; i < 4; i++)
        begin
            j = (i + 1) % 4;
            wr(OFS_CTRL, 32'((4 + i) << CTRL_ACQ_LSB | (4 + j) << CTRL_FRM_LSB));
            pulse_line(i, 10);
            chk(da, 1);
            chk(df, 0);
            pulse_line(j, 10);
            chk(df, 1);
            chk(da, 0);
        end
        $display("test trigger_route done");
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_CTRL, 32'(1 << i | (4 + i) << CTRL_ACQ_LSB));
            repeat (8) @(posedge MCLK_IN);
            chk(32'(lvl), 32'(1 << i));
            pulse_line(i, 10);
            chk(da, 1);
        end
        $display("test invert done");
        wr(OFS_CTRL, 32'(1 << CTRL_DIR_BIT | 1 << CTRL_PINOUT_BIT | 4 << CTRL_ACQ_LSB));
        repeat (4) @(posedge MCLK_IN);
        chk({30'h0, pin_oe, pin_o}, 32'h3);
        chk(32'(lvl), 32'h0);
        wr(OFS_CTRL, 32'(1 << CTRL_DIR_BIT | 4 << CTRL_ACQ_LSB));
        a0 = acq_cnt;
        for (int k = 0; k < 8; k++)
        begin
            rng = xorshift(rng);
            @(posedge MCLK_IN);
            pin_src <= rng[0] ^ k[0];
            repeat (3) @(posedge MCLK_IN);
            chk({31'h0, pin_o}, {31'h0, rng[0] ^ k[0]});
        end
        chk(acq_cnt - a0, 0);
        wr(OFS_CTRL, 32'h0);
        repeat (4) @(posedge MCLK_IN);
        chk({31'h0, pin_oe}, 32'h0);
        wr(OFS_CTRL, 32'(1 << CTRL_SPARE_BIT));
        repeat (2) @(posedge MCLK_IN);
        chk({31'h0, spare}, 32'h1);
        $display("test direction done");
        wr(TOFS[1], 32'h2);
        wr(OFS_CTRL, 32'h0);
        line_source_model_inst.set_line(1, 1'b1);
        n = 0;
        while (lvl[1] !== 1'b1 && n < 400)
        begin
            @(posedge MCLK_IN);
            n++;
        end
        chk(32'(n >= 2 * CLK_MHZ && n <= 3 * CLK_MHZ + 6), 32'h1);
        bad = 0;
        fork
            for (int k = 0; k < 3; k++)
            begin
                rng = xorshift(rng);
                line_source_model_inst.pulse(1, 1'b0, 10 + int'(rng[5:0]) % 80);
            end
            repeat (600)
            begin
                @(posedge MCLK_IN);
                bad += int'(lvl[1] !== 1'b1);
            end
        join
        chk(bad, 0);
        $display("test glitch done");
        end_sim();
    end
endmodule : tb_camera_input_line_conditioning
